// ### logic/mies_pkg.sv
`default_nettype none
package mies_pkg;
	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int ADDR_W    = 8;
	localparam int DATA_W    = 32;
	localparam int PC_W      = 11;
	localparam int NIB_W     = 4;
	localparam int MEM_AW    = 7;
	localparam int MEM_DEPTH = 128;
	localparam int WDT_W     = 12;
	localparam int PRE_W     = 10;
	localparam int EVF_W     = 4;
	localparam int IRQ_W     = 4;
	localparam int SYNC_W    = 3;
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] REG_CMD     = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATE   = 8'h04;
	localparam logic [ADDR_W-1:0] REG_WDT     = 8'h08;
	localparam logic [ADDR_W-1:0] REG_HEF     = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_EVF     = 8'h10;
	localparam logic [ADDR_W-1:0] REG_MADDR   = 8'h14;
	localparam logic [ADDR_W-1:0] REG_MDATA   = 8'h18;
	localparam logic [ADDR_W-1:0] REG_IRQ_STS = 8'h1c;
	localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 8'h20;
	localparam logic [ADDR_W-1:0] REG_IRQ_EN  = 8'h24;
	localparam logic [ADDR_W-1:0] REG_INTSRC  = 8'h28;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_ADDR_LSB = 4;
	localparam int CMD_IMM_LSB  = 12;
	localparam int ST_ACC_LSB   = 11;
	localparam int ST_CF        = 15;
	localparam int ST_ZF        = 16;
	localparam int ST_IE        = 17;
	localparam int ST_HOLD      = 18;
	localparam int ST_WSEL      = 19;
	localparam int ST_ISRH      = 20;
	localparam int PARAM_WDT    = 3;
	localparam int EVF_PORT     = 2;
	localparam int IRQ_HOLDX    = 0;
	localparam int IRQ_ACCEPT   = 1;
	localparam int IRQ_WDTOVF   = 2;
	localparam int IRQ_SKIP     = 3;
	// ------------------------------------------------------------
	// reset values and counts
	// ------------------------------------------------------------
	localparam logic [PC_W-1:0]  PC_RESET   = 11'h000;
	localparam logic [PC_W-1:0]  INT_VECTOR = 11'h004;
	localparam logic [PC_W-1:0]  PC_STEP    = 11'h001;
	localparam logic [PC_W-1:0]  PC_SKIP    = 11'h002;
	localparam logic [NIB_W-1:0] NIB_ONE    = 4'h1;
	localparam logic [NIB_W-1:0] NIB_ZERO   = 4'h0;
	localparam logic [PRE_W-1:0] PRE_SLOW   = 10'h3ff;
	localparam logic [PRE_W-1:0] PRE_FAST   = 10'h00f;
	localparam logic [WDT_W-1:0] WDT_ONE    = 12'h001;
	localparam logic [WDT_W-1:0] WDT_MAX    = 12'hfff;
	localparam logic [PRE_W-1:0] PRE_ONE    = 10'h001;
	// ------------------------------------------------------------
	// operation codes
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NOP, OP_CLR_PARAM, OP_CLR_PORT, OP_CLEAR_WATCHDOG_LOW_OP, OP_DEC, OP_DECREMENT_SKIP_NONZERO_OP, OP_DECREMENT_SKIP_ZERO_OP,
		OP_INT_DIS, OP_INT_EN, OP_HOLD, OP_RET, OP_CLR_EVF
	} mies_op_t;
endpackage
`default_nettype wire

// ### logic/mies_core.sv
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - param op bit3 selects slow watchdog clock
// - port change op clears change flag
// - watchdog clear resets only low four bits
// - decrement writes memory and accumulator, flags
// - decrement, skip two when result nonzero
// - decrement, skip two when result zero
// - disable op blocks interrupt acceptance
// - enable op allows interrupt acceptance
// - hold op enters hold; interrupt/event releases
// - return after hold interrupt re-enters hold
module mies_core (
	// clock and reset
	input  wire logic                          CORE_CLK,
	input  wire logic                          RSTN,
	// apb slave
	input  wire logic [mies_pkg::ADDR_W-1:0]   PADDR,
	input  wire logic                          PSEL,
	input  wire logic                          PENABLE,
	input  wire logic                          PWRITE,
	input  wire logic [mies_pkg::DATA_W-1:0]   PWDATA,
	output logic      [mies_pkg::DATA_W-1:0]   PRDATA,
	output logic                               PREADY,
	output logic                               PSLVERR,
	// event pins
	input  wire logic [mies_pkg::NIB_W-1:0]    CHANGE_PORT,
	input  wire logic [2:0]                    EVENT_IN,
	// status out
	output logic                               IRQ,
	output logic                               HOLD_OUT
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [mies_pkg::NIB_W-1:0]  mem_q [mies_pkg::MEM_DEPTH];
	logic [mies_pkg::PC_W-1:0]   pc_q, ret_q;
	logic [mies_pkg::NIB_W-1:0]  acc_q;
	logic                        cf_q, zf_q, ie_q, hold_q, isrh_q, wsel_q;
	logic [mies_pkg::WDT_W-1:0]  wdt_q;
	logic [mies_pkg::PRE_W-1:0]  pre_q;
	logic [mies_pkg::EVF_W-1:0]  evf_q, hef_q, isrc_q;
	logic [mies_pkg::MEM_AW-1:0] maddr_q;
	logic [mies_pkg::IRQ_W-1:0]  sts_q, en_q;
	logic                        pready_q, pslverr_q, irq_q;
	logic [mies_pkg::DATA_W-1:0] prdata_q;
	logic [mies_pkg::NIB_W-1:0]  port_s_q [mies_pkg::SYNC_W];
	logic [2:0]                  ev_s_q [mies_pkg::SYNC_W];

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	logic                        acc_fire, wr_fire, exec, accept, tick, wdt_ovf, skip;
	logic                        hef_hit, dec_op;
	mies_pkg::mies_op_t          op;
	logic [mies_pkg::MEM_AW-1:0] op_addr;
	logic [mies_pkg::NIB_W-1:0]  op_imm, dec_res, mem_rd;
	logic [mies_pkg::EVF_W-1:0]  ev_rise;
	logic [mies_pkg::IRQ_W-1:0]  sts_set;

	// bus transfer completes on the edge that samples pready high
	assign acc_fire = PSEL && PENABLE && pready_q;
	assign wr_fire  = acc_fire && PWRITE;
	// commands are refused while holding
	assign exec     = wr_fire && (PADDR == mies_pkg::REG_CMD) && !hold_q;
	assign op       = mies_pkg::mies_op_t'(PWDATA[mies_pkg::CMD_OP_LSB +: 4]);
	assign op_addr  = PWDATA[mies_pkg::CMD_ADDR_LSB +: mies_pkg::MEM_AW];
	assign op_imm   = PWDATA[mies_pkg::CMD_IMM_LSB +: mies_pkg::NIB_W];
	assign mem_rd   = mem_q[op_addr];
	assign dec_res  = mem_rd - mies_pkg::NIB_ONE;
	assign dec_op   = exec && (op == mies_pkg::OP_DEC || op == mies_pkg::OP_DECREMENT_SKIP_NONZERO_OP
		|| op == mies_pkg::OP_DECREMENT_SKIP_ZERO_OP);
	assign skip     = exec && ((op == mies_pkg::OP_DECREMENT_SKIP_NONZERO_OP && dec_res != mies_pkg::NIB_ZERO)
		|| (op == mies_pkg::OP_DECREMENT_SKIP_ZERO_OP && dec_res == mies_pkg::NIB_ZERO));
	// interrupt taken only when enabled and no command in flight
	assign accept   = ie_q && |(evf_q & isrc_q) && !exec;
	// event flag sources: div0, timer0, port change, div1
	assign ev_rise  = {ev_s_q[1][2] && !ev_s_q[2][2], port_s_q[1] != port_s_q[2],
		ev_s_q[1][1] && !ev_s_q[2][1], ev_s_q[1][0] && !ev_s_q[2][0]};
	assign hef_hit  = |(ev_rise & hef_q);
	assign tick     = wsel_q ? (pre_q == mies_pkg::PRE_SLOW) : (pre_q == mies_pkg::PRE_FAST);
	assign wdt_ovf  = tick && (wdt_q == mies_pkg::WDT_MAX);
	assign sts_set  = {skip, wdt_ovf, accept, hold_q && (accept || hef_hit)};

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// three stages: two to settle, one more for edge detect
	always_ff @(posedge CORE_CLK) begin
		port_s_q[0] <= CHANGE_PORT;
		ev_s_q[0]   <= EVENT_IN;
		for (int i = 1; i < mies_pkg::SYNC_W; i++) begin
			port_s_q[i] <= port_s_q[i-1];
			ev_s_q[i]   <= ev_s_q[i-1];
		end
	end

	// ------------------------------------------------------------
	// data memory
	// ------------------------------------------------------------
	// one writer per cycle: a command or a window write
	always_ff @(posedge CORE_CLK) begin
		if (dec_op) begin
			mem_q[op_addr] <= dec_res;
		end else if (wr_fire && PADDR == mies_pkg::REG_MDATA) begin
			mem_q[maddr_q] <= PWDATA[mies_pkg::NIB_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// accumulator and flags
	// ------------------------------------------------------------
	// carry set when no borrow
	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			acc_q <= mies_pkg::NIB_ZERO;
			cf_q  <= 1'b0;
			zf_q  <= 1'b0;
		end else if (dec_op) begin
			acc_q <= dec_res;
			cf_q  <= (mem_rd != mies_pkg::NIB_ZERO);
			zf_q  <= (dec_res == mies_pkg::NIB_ZERO);
		end
	end

	// ------------------------------------------------------------
	// program counter, interrupt and hold
	// ------------------------------------------------------------
	// interrupt accept first, then hold, then commands
	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			pc_q   <= mies_pkg::PC_RESET;
			ret_q  <= mies_pkg::PC_RESET;
			ie_q   <= 1'b0;
			hold_q <= 1'b0;
			isrh_q <= 1'b0;
		end else if (accept) begin
			ret_q  <= pc_q;
			pc_q   <= mies_pkg::INT_VECTOR;
			ie_q   <= 1'b0;
			hold_q <= 1'b0;
			isrh_q <= hold_q;
		end else if (hold_q) begin
			if (hef_hit) begin
				hold_q <= 1'b0;
			end
		end else if (exec) begin
			pc_q <= pc_q + (skip ? mies_pkg::PC_SKIP : mies_pkg::PC_STEP);
			unique case (op)
				mies_pkg::OP_INT_DIS: begin
					ie_q <= 1'b0;
				end
				mies_pkg::OP_INT_EN: begin
					ie_q <= 1'b1;
				end
				mies_pkg::OP_HOLD: begin
					hold_q <= 1'b1;
				end
				mies_pkg::OP_RET: begin
					pc_q   <= ret_q;
					ie_q   <= 1'b1;
					hold_q <= isrh_q;
					isrh_q <= 1'b0;
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// watchdog
	// ------------------------------------------------------------
	// prescaler runs free; low nibble clear wins over a tick
	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			wsel_q <= 1'b0;
			pre_q  <= '0;
			wdt_q  <= '0;
		end else begin
			pre_q <= tick ? '0 : pre_q + mies_pkg::PRE_ONE;
			if (exec && op == mies_pkg::OP_CLR_PARAM && op_imm[mies_pkg::PARAM_WDT]) begin
				wsel_q <= 1'b1;
			end
			if (exec && op == mies_pkg::OP_CLEAR_WATCHDOG_LOW_OP) begin
				wdt_q[3:0] <= '0;
			end else if (tick) begin
				wdt_q <= wdt_q + mies_pkg::WDT_ONE;
			end
		end
	end

	// ------------------------------------------------------------
	// event flags, set wins over clear
	// ------------------------------------------------------------
	// pin edges set flags; ops clear the chosen bits
	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			evf_q <= '0;
		end else if (exec && op == mies_pkg::OP_CLR_PORT) begin
			evf_q <= (evf_q & ~(4'h1 << mies_pkg::EVF_PORT)) | ev_rise;
		end else if (exec && op == mies_pkg::OP_CLR_EVF) begin
			evf_q <= (evf_q & ~op_imm) | ev_rise;
		end else begin
			evf_q <= evf_q | ev_rise;
		end
	end

	// ------------------------------------------------------------
	// software registers and interrupt status
	// ------------------------------------------------------------
	// plain register writes; status sticky, set wins
	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			hef_q   <= '0;
			isrc_q  <= '0;
			maddr_q <= '0;
			en_q    <= '0;
			sts_q   <= '0;
			irq_q   <= 1'b0;
		end else begin
			if (wr_fire && PADDR == mies_pkg::REG_HEF) hef_q <= PWDATA[mies_pkg::EVF_W-1:0];
			if (wr_fire && PADDR == mies_pkg::REG_INTSRC) isrc_q <= PWDATA[mies_pkg::EVF_W-1:0];
			if (wr_fire && PADDR == mies_pkg::REG_MADDR) maddr_q <= PWDATA[mies_pkg::MEM_AW-1:0];
			if (wr_fire && PADDR == mies_pkg::REG_IRQ_EN) en_q <= PWDATA[mies_pkg::IRQ_W-1:0];
			if (wr_fire && PADDR == mies_pkg::REG_IRQ_CLR) begin
				sts_q <= (sts_q & ~PWDATA[mies_pkg::IRQ_W-1:0]) | sts_set;
			end else begin
				sts_q <= sts_q | sts_set;
			end
			irq_q <= |(sts_q & en_q);
		end
	end

	// ------------------------------------------------------------
	// apb answer, one wait state
	// ------------------------------------------------------------
	// every access answered after one wait state
	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
		end else begin
			pready_q  <= PSEL && PENABLE && !pready_q;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
			if (PSEL && PENABLE && !pready_q) begin
				unique case (PADDR)
					mies_pkg::REG_CMD, mies_pkg::REG_IRQ_CLR: begin
					end
					mies_pkg::REG_STATE: begin
						prdata_q[mies_pkg::PC_W-1:0]                 <= pc_q;
						prdata_q[mies_pkg::ST_ACC_LSB +: mies_pkg::NIB_W] <= acc_q;
						prdata_q[mies_pkg::ST_CF]   <= cf_q;
						prdata_q[mies_pkg::ST_ZF]   <= zf_q;
						prdata_q[mies_pkg::ST_IE]   <= ie_q;
						prdata_q[mies_pkg::ST_HOLD] <= hold_q;
						prdata_q[mies_pkg::ST_WSEL] <= wsel_q;
						prdata_q[mies_pkg::ST_ISRH] <= isrh_q;
					end
					mies_pkg::REG_WDT:     prdata_q[mies_pkg::WDT_W-1:0]  <= wdt_q;
					mies_pkg::REG_HEF:     prdata_q[mies_pkg::EVF_W-1:0]  <= hef_q;
					mies_pkg::REG_EVF:     prdata_q[mies_pkg::EVF_W-1:0]  <= evf_q;
					mies_pkg::REG_MADDR:   prdata_q[mies_pkg::MEM_AW-1:0] <= maddr_q;
					mies_pkg::REG_MDATA:   prdata_q[mies_pkg::NIB_W-1:0]  <= mem_q[maddr_q];
					mies_pkg::REG_IRQ_STS: prdata_q[mies_pkg::IRQ_W-1:0]  <= sts_q;
					mies_pkg::REG_IRQ_EN:  prdata_q[mies_pkg::IRQ_W-1:0]  <= en_q;
					mies_pkg::REG_INTSRC:  prdata_q[mies_pkg::EVF_W-1:0]  <= isrc_q;
					default:               pslverr_q <= 1'b1;
				endcase
			end
		end
	end

	// top outputs come straight from flops
	assign PRDATA   = prdata_q;
	assign PREADY   = pready_q;
	assign PSLVERR  = pslverr_q;
	assign IRQ      = irq_q;
	assign HOLD_OUT = hold_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);
	// pc checks rely on accept never meeting exec

	param_sel_a: assert property (exec && op == mies_pkg::OP_CLR_PARAM && op_imm[3] |=> wsel_q)
		else $error("param op did not select slow watchdog clock");
	port_clr_a: assert property (exec && op == mies_pkg::OP_CLR_PORT && !ev_rise[2]
		|=> !evf_q[2])
		else $error("port change flag not cleared");
	wdt_low_a: assert property (exec && op == mies_pkg::OP_CLEAR_WATCHDOG_LOW_OP
		|=> wdt_q[3:0] == 4'h0 && wdt_q[11:4] == $past(wdt_q[11:4]))
		else $error("watchdog clear touched wrong bits");
	dec_mem_a: assert property (dec_op |=> acc_q == $past(dec_res)
		&& mem_q[$past(op_addr)] == acc_q && zf_q == (acc_q == 4'h0))
		else $error("decrement result wrong");
	skip_nz_a: assert property (exec && op == mies_pkg::OP_DECREMENT_SKIP_NONZERO_OP
		|=> pc_q == $past(pc_q) + ((acc_q != 4'h0) ? 11'h002 : 11'h001))
		else $error("nonzero skip step wrong");
	skip_z_a: assert property (exec && op == mies_pkg::OP_DECREMENT_SKIP_ZERO_OP
		|=> pc_q == $past(pc_q) + ((acc_q == 4'h0) ? 11'h002 : 11'h001))
		else $error("zero skip step wrong");
	int_dis_a: assert property (exec && op == mies_pkg::OP_INT_DIS
		|=> !ie_q ##0 (!accept throughout (!ie_q)[*2]))
		else $error("interrupt accepted while disabled");
	int_en_a: assert property (exec && op == mies_pkg::OP_INT_EN |=> ie_q)
		else $error("interrupt enable op ignored");
	hold_in_a: assert property (exec && op == mies_pkg::OP_HOLD |=> hold_q && HOLD_OUT)
		else $error("hold not entered");
	hold_again_a: assert property (exec && op == mies_pkg::OP_RET && isrh_q
		|=> hold_q)
		else $error("hold not re-entered after return");
	hef_release_a: assert property (hold_q && !accept && hef_hit
		|=> !hold_q && $stable(pc_q))
		else $error("enabled event did not release hold");
	irq_level_a: assert property (|(sts_q & en_q) |=> IRQ)
		else $error("interrupt line low with enabled status");
	accept_vec_a: assert property (accept |=> pc_q == mies_pkg::INT_VECTOR && !ie_q && !hold_q)
		else $error("accepted interrupt did not vector");
	dec_carry_a: assert property (dec_op |=> cf_q == ($past(mem_rd) != 4'h0))
		else $error("decrement carry wrong");
	hold_still_a: assert property (hold_q && !accept && !hef_hit |=> hold_q && $stable(pc_q))
		else $error("hold left without a release");
	ret_ie_a: assert property (exec && op == mies_pkg::OP_RET |=> ie_q && pc_q == $past(ret_q))
		else $error("return did not restore pc and enable");

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	// main scenarios worth seeing
	skip_cv: cover property (skip);
	hold_int_cv: cover property (hold_q && accept);
	hold_ev_cv: cover property (hold_q && hef_hit && !accept);
	ret_hold_cv: cover property (exec && op == mies_pkg::OP_RET && isrh_q);
	wdt_clr_cv: cover property (exec && op == mies_pkg::OP_CLEAR_WATCHDOG_LOW_OP);
endmodule
`default_nettype wire

// ### tb/mies_events.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// event pin source facing the core
// ------------------------------------------------------------
module mies_events (
	// clock
	input  wire logic       clk,
	// requests from the bench
	input  wire logic [2:0] fire,
	input  wire logic [3:0] port_val,
	// pins toward the core
	output logic      [3:0] port_pins,
	output logic      [2:0] ev_pins
);
	logic [3:0] port_q = 4'h0;
	logic [2:0] ev_q   = 3'h0;
	logic [2:0] cnt_q  = 3'h0;

	// port pins follow the requested level one edge later
	always @(posedge clk) begin
		port_q <= port_val;
	end

	// event pulse held a few cycles so the synchroniser sees it
	always @(posedge clk) begin
		if (fire != 3'h0) begin
			ev_q  <= fire;
			cnt_q <= 3'h4;
		end else if (cnt_q != 3'h0) begin
			cnt_q <= cnt_q - 3'h1;
		end else begin
			ev_q <= 3'h0;
		end
	end

	// drive pins
	assign port_pins = port_q;
	assign ev_pins   = ev_q;
endmodule
`default_nettype wire

// ### tb/mies_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
module mies_core_bench;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic        clk      = 1'b0;
	logic        rstn     = 1'b0;
	logic [7:0]  paddr    = 8'h00;
	logic        psel     = 1'b0;
	logic        penable  = 1'b0;
	logic        pwrite   = 1'b0;
	logic [31:0] pwdata   = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        hold_out;
	logic [3:0]  port_pins;
	logic [3:0]  port_val = 4'h0;
	logic [2:0]  ev_pins;
	logic [2:0]  fire     = 3'h0;
	logic [64:0] q[$];
	logic [64:0] ent;
	logic [31:0] lfsr     = 32'h2e04;
	logic [31:0] tmp;
	logic [10:0] pc       = 11'h000;
	logic [10:0] ret;
	logic [3:0]  v;
	logic [3:0]  r;
	logic        sk;
	int          n_errors = 0;
	int          compares = 0;
	int          cyc      = 0;

	// clock at 200 MHz
	initial forever #2.5 clk = ~clk;

	mies_core dut (.CORE_CLK(clk), .RSTN(rstn), .PADDR(paddr), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .CHANGE_PORT(port_pins),
		.EVENT_IN(ev_pins), .IRQ(irq), .HOLD_OUT(hold_out));
	mies_events src (.clk(clk), .fire(fire), .port_val(port_val),
		.port_pins(port_pins), .ev_pins(ev_pins));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction

	task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic test_done();
		if (q.size() != 0) n_errors++;
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// one apb transfer; expected result noted for the monitor
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic er);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		q.push_back({er, m, d});
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 1'b0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(1'b0, a, e, m, 1'b0);
	endtask

	task automatic rs(input logic [31:0] e, input logic [31:0] m);
		rd(mies_pkg::REG_STATE, e, m);
	endtask

	task automatic op(input mies_pkg::mies_op_t o, input logic [6:0] ad, input logic [3:0] im);
		wr(mies_pkg::REG_CMD, {16'h0, im, 1'b0, ad, o});
	endtask

	task automatic chk_irq(input logic e);
		repeat (2) @(posedge clk);
		cmp("irq pin", {31'h0, e}, {31'h0, irq});
	endtask

	task automatic wait_hold(input logic e);
		int n;
		n = 0;
		while (hold_out !== e && n < 40) begin
			@(posedge clk);
			n++;
		end
		cmp("hold pin", {31'h0, e}, {31'h0, hold_out});
	endtask

	task automatic ev(input logic [2:0] f);
		@(posedge clk);
		fire <= f;
		@(posedge clk);
		fire <= 3'h0;
		repeat (12) @(posedge clk);
	endtask

	// ------------------------------------------------------------
	// monitor: compare each completed transfer with the oldest note
	// ------------------------------------------------------------
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (psel && penable && pready === 1'b1 && q.size() != 0) begin
			ent = q.pop_front();
			cmp("read data", ent[31:0] & ent[63:32], prdata & ent[63:32]);
			cmp("error flag", {31'h0, ent[64]}, {31'h0, pslverr});
		end
		if (cyc == 20000) begin
			n_errors++;
			test_done();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		rs(32'h0, 32'h001e07ff);
		cmp("irq pin", 32'h0, {31'h0, irq});
		rd(mies_pkg::REG_CMD, 32'h0, 32'hffffffff);
		apb(1'b0, 8'h2c, 32'h0, 32'hffffffff, 1'b1);
		apb(1'b1, 8'h2c, 32'h5, 32'h0, 1'b1);
		// watchdog reaches 0x027..0x028, then low nibble cleared
		while (cyc < 640) @(posedge clk);
		op(mies_pkg::OP_CLEAR_WATCHDOG_LOW_OP, 7'h0, 4'h0);
		pc += 11'h1;
		rd(mies_pkg::REG_WDT, 32'h20, 32'hffe);
		// slow watchdog select: reserved bits, bit3, then sticky
		for (int i = 0; i < 3; i++) begin
			op(mies_pkg::OP_CLR_PARAM, 7'h0, (i == 0) ? 4'h7 : (i == 1) ? 4'h8 : 4'h0);
			pc += 11'h1;
			rs({12'h0, i != 0, 8'h0, pc}, 32'h000807ff);
		end
		// decrement family over boundary and random values
		for (int o = 4; o <= 6; o++) begin
			for (int k = 0; k < 4; k++) begin
				tmp = rnd();
				v = (k == 3) ? tmp[3:0] : k[3:0];
				r = v - 4'h1;
				sk = (o == 5 && r != 4'h0) || (o == 6 && r == 4'h0);
				wr(mies_pkg::REG_MADDR, {25'h0, tmp[10:4]});
				wr(mies_pkg::REG_MDATA, {28'h0, v});
				op(mies_pkg::mies_op_t'(o), tmp[10:4], 4'h0);
				pc += sk ? 11'h2 : 11'h1;
				rs({15'h0, r == 4'h0, v != 4'h0, r, pc}, 32'h1ffff);
				rd(mies_pkg::REG_MDATA, {28'h0, r}, 32'hf);
			end
		end
		// skip status: raise, mask, unmask, clear
		wr(mies_pkg::REG_IRQ_EN, 32'h8);
		chk_irq(1'b1);
		wr(mies_pkg::REG_IRQ_EN, 32'h0);
		chk_irq(1'b0);
		wr(mies_pkg::REG_IRQ_EN, 32'h8);
		chk_irq(1'b1);
		wr(mies_pkg::REG_IRQ_CLR, 32'hf);
		chk_irq(1'b0);
		rd(mies_pkg::REG_IRQ_STS, 32'h0, 32'h8);
		// port change flag set by pins, cleared by op
		tmp = rnd();
		port_val <= port_val ^ (tmp[3:0] | 4'h1);
		repeat (8) @(posedge clk);
		rd(mies_pkg::REG_EVF, 32'h4, 32'h4);
		op(mies_pkg::OP_CLR_PORT, 7'h0, 4'h0);
		pc += 11'h1;
		rd(mies_pkg::REG_EVF, 32'h0, 32'h4);
		// disabled: pending source not accepted
		wr(mies_pkg::REG_INTSRC, 32'h1);
		op(mies_pkg::OP_INT_DIS, 7'h0, 4'h0);
		pc += 11'h1;
		ev(3'h1);
		rs({14'h0, 1'b0, 6'h0, pc}, 32'h207ff);
		rd(mies_pkg::REG_IRQ_STS, 32'h0, 32'h2);
		// enable: accepted at once, vector taken
		op(mies_pkg::OP_INT_EN, 7'h0, 4'h0);
		ret = pc + 11'h1;
		rs({21'h0, 11'h004}, 32'h207ff);
		rd(mies_pkg::REG_IRQ_STS, 32'h2, 32'h2);
		op(mies_pkg::OP_CLR_EVF, 7'h0, 4'hf);
		op(mies_pkg::OP_RET, 7'h0, 4'h0);
		pc = ret;
		rs({14'h0, 1'b1, 6'h0, pc}, 32'h207ff);
		// hold released by an enabled event flag
		wr(mies_pkg::REG_INTSRC, 32'h0);
		wr(mies_pkg::REG_HEF, 32'h2);
		op(mies_pkg::OP_HOLD, 7'h0, 4'h0);
		pc += 11'h1;
		wait_hold(1'b1);
		op(mies_pkg::OP_INT_DIS, 7'h0, 4'h0);
		rs({13'h0, 1'b1, 1'b1, 6'h0, pc}, 32'h607ff);
		ev(3'h2);
		wait_hold(1'b0);
		rs({13'h0, 1'b0, 1'b1, 6'h0, pc}, 32'h607ff);
		rd(mies_pkg::REG_IRQ_STS, 32'h1, 32'h1);
		// interrupt out of hold, return goes back into hold
		op(mies_pkg::OP_CLR_EVF, 7'h0, 4'hf);
		wr(mies_pkg::REG_INTSRC, 32'h8);
		op(mies_pkg::OP_HOLD, 7'h0, 4'h0);
		ret = pc + 11'h2;
		wait_hold(1'b1);
		ev(3'h4);
		wait_hold(1'b0);
		rs({11'h0, 1'b1, 9'h0, 11'h004}, 32'h1007ff);
		op(mies_pkg::OP_CLR_EVF, 7'h0, 4'hf);
		op(mies_pkg::OP_RET, 7'h0, 4'h0);
		wait_hold(1'b1);
		rs({21'h0, ret}, 32'h7ff);
		ev(3'h2);
		wait_hold(1'b0);
		test_done();
	end
endmodule
`default_nettype wire
